// *** rmp_margin_regs.sv ***
`timescale 1ns/1ps
`include "rmp_consts.svh"
module rmp_margin_regs (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Supply monitor pin, high while below falling threshold
  input  wire logic              supply_low,
  // Register port from the serial framing logic
  input  wire logic              reg_wr_en,
  input  wire logic [7:0]        reg_wr_addr,
  input  wire logic [7:0]        reg_wr_data,
  input  wire logic              reg_txn_done,
  input  wire logic [7:0]        reg_rd_addr,
  output logic [7:0]             reg_rd_data,
  // Regulator references and mode
  input  wire rmp_pkg::rmp_vref_t nb_vref_mv,
  input  wire rmp_pkg::rmp_vref_t core_vref_mv,
  input  wire logic              psave_active,
  // North-bridge operating parameters
  output rmp_pkg::rmp_mv_t       nb_target_mv,
  output rmp_pkg::rmp_mv_t       nb_ovp_mv,
  output rmp_pkg::rmp_mv_t       nb_pg_low_mv,
  output rmp_pkg::rmp_mv_t       nb_pg_low_rel_mv,
  // Core operating parameters
  output rmp_pkg::rmp_mv_t       core_target_mv,
  output rmp_pkg::rmp_mv_t       core_ovp_mv,
  output rmp_pkg::rmp_mv_t       core_pg_low_mv,
  output rmp_pkg::rmp_mv_t       core_pg_low_rel_mv,
  output rmp_pkg::rmp_mv_t       core_pg_high_mv,
  output rmp_pkg::rmp_mv_t       core_pg_high_rel_mv,
  // Power-save phase shedding
  output logic [1:0]             psave_phase_code,
  output logic [2:0]             psave_add_cycles,
  output logic [2:0]             psave_drop_cycles
);
  import rmp_pkg::*;

  rmp_regs_if rb ();

  // Supply monitor comes from the analog side, so synchronise it
  logic sync1_reg, sync1_next;
  logic sync2_reg, sync2_next;
  logic clr;

  // First stage may go metastable; only the second stage is read
  always_comb begin
    sync1_next = supply_low;
    sync2_next = sync1_reg;
  end

  // Synchroniser flops
  always_ff @(posedge sys_clk) begin
    sync1_reg <= sync1_next;
    sync2_reg <= sync2_next;
  end

  // Either source clears the bank; the supply path lags its pin by two clocks
  // Bytes landing during a clear are lost, which suits a failing supply
  assign clr = rst | sync2_reg;

  // Address decode
  function automatic rmp_reg_sel_t dec_addr(input logic [7:0] a);
    case (a)
      `RMP_ADDR_NB:    dec_addr = RMP_REG_NB;
      `RMP_ADDR_CORE:  dec_addr = RMP_REG_CORE;
      `RMP_ADDR_PSAVE: dec_addr = RMP_REG_PSAVE;
      default:         dec_addr = RMP_REG_NONE;
    endcase
  endfunction

  // Signed offset code to mV
  function automatic rmp_mv_t ofs_mv(input logic [5:0] c);
    rmp_mv_t e;
    e = {{8{c[`RMP_OFS_SIGN]}}, c};
    ofs_mv = e * `RMP_OFS_STEP_MV;
  endfunction

  // Spacing code to PWM cycles, zero meaning all phases at once
  function automatic logic [2:0] space_cyc(input logic [1:0] c);
    case (c)
      2'h0:    space_cyc = `RMP_SPACE_1;
      2'h1:    space_cyc = `RMP_SPACE_2;
      2'h2:    space_cyc = `RMP_SPACE_4;
      default: space_cyc = `RMP_SPACE_ALL;
    endcase
  endfunction

  // Overvoltage trip: floor or target plus margin, whichever greater
  function automatic rmp_mv_t ovp_mv(input rmp_mv_t tgt, input logic hi);
    rmp_mv_t t;
    t = tgt + (hi ? `RMP_OVP_HI_MV : `RMP_OVP_LO_MV);
    ovp_mv = (t > `RMP_OVP_FLOOR_MV) ? t : `RMP_OVP_FLOOR_MV;
  endfunction

  // Low power-good trip below target, widened by the window bit
  function automatic rmp_mv_t pg_low_mv(input rmp_mv_t tgt, input logic wide);
    pg_low_mv = tgt - (wide ? `RMP_PG_DN_HI_MV : `RMP_PG_DN_LO_MV);
  endfunction

  // Low trip releases one hysteresis step above its trip point
  function automatic rmp_mv_t pg_rel_mv(input rmp_mv_t trip);
    pg_rel_mv = trip + `RMP_PG_HYST_MV;
  endfunction

  // Byte port into the store
  assign rb.wr_en   = reg_wr_en;
  assign rb.wr_sel  = dec_addr(reg_wr_addr);
  assign rb.wr_data = reg_wr_data;
  assign rb.apply   = reg_txn_done;
  assign rb.rd_sel  = dec_addr(reg_rd_addr);

  // Staged and live register copies
  rmp_reg_store u_store (
    .sys_clk (sys_clk),
    .clr     (clr),
    .rb      (rb.store)
  );

  // Registered parameter outputs
  rmp_byte_t rd_reg, rd_next;
  rmp_mv_t   nb_tgt_reg, nb_tgt_next;
  rmp_mv_t   nb_ovp_reg, nb_ovp_next;
  rmp_mv_t   nb_pgl_reg, nb_pgl_next;
  rmp_mv_t   nb_pglr_reg, nb_pglr_next;
  rmp_mv_t   co_tgt_reg, co_tgt_next;
  rmp_mv_t   co_ovp_reg, co_ovp_next;
  rmp_mv_t   co_pgl_reg, co_pgl_next;
  rmp_mv_t   co_pglr_reg, co_pglr_next;
  rmp_mv_t   co_pgh_reg, co_pgh_next;
  rmp_mv_t   co_pghr_reg, co_pghr_next;
  logic [1:0] ph_reg, ph_next;
  logic [2:0] add_reg, add_next;
  logic [2:0] drop_reg, drop_next;

  // Derive operating thresholds from the live register copy
  always_comb begin
    rmp_mv_t nb_ref;
    rmp_mv_t co_ref;
    rmp_mv_t co_ofs;
    logic    nb_pgw;
    logic    co_pgw;
    nb_ref = rmp_mv_t'({2'h0, nb_vref_mv});
    co_ref = rmp_mv_t'({2'h0, core_vref_mv});
    nb_pgw = rb.live_nb[`RMP_PGOOD_BIT];
    co_pgw = rb.live_core[`RMP_PGOOD_BIT];
    co_ofs = ofs_mv(rb.live_core[`RMP_OFS_MSB:0]);
    // Offset can be dropped while shedding to save light-load power
    if (psave_active && rb.live_psave[`RMP_PS_OFS_DIS_BIT]) begin
      co_ofs = 14'sh0000;
    end
    rd_next      = rb.rd_data;
    nb_tgt_next  = nb_ref + ofs_mv(rb.live_nb[`RMP_OFS_MSB:0]);
    co_tgt_next  = co_ref + co_ofs;
    // Trip levels track the shifted target, not the raw reference
    nb_ovp_next  = ovp_mv(nb_tgt_next, rb.live_nb[`RMP_OVP_BIT]);
    co_ovp_next  = ovp_mv(co_tgt_next, rb.live_core[`RMP_OVP_BIT]);
    // Both rails trip low; only the core has a high trip
    nb_pgl_next  = pg_low_mv(nb_tgt_next, nb_pgw);
    co_pgl_next  = pg_low_mv(co_tgt_next, co_pgw);
    co_pgh_next  = co_tgt_next + (co_pgw ? `RMP_PG_UP_HI_MV : `RMP_PG_UP_LO_MV);
    // Release points sit inside the window to stop chatter
    nb_pglr_next = pg_rel_mv(nb_pgl_next);
    co_pglr_next = pg_rel_mv(co_pgl_next);
    co_pghr_next = co_pgh_next - `RMP_PG_HYST_MV;
    // Codes 10 and 11 pass through untouched to the phase controller
    ph_next   = rb.live_psave[`RMP_PS_PH_MSB:`RMP_PS_PH_LSB];
    add_next  = space_cyc(rb.live_psave[`RMP_PS_ADD_MSB:`RMP_PS_ADD_LSB]);
    drop_next = space_cyc(rb.live_psave[`RMP_PS_DROP_MSB:`RMP_PS_DROP_LSB]);
  end

  // Output pipeline, so every output leaves a flop
  always_ff @(posedge sys_clk) begin
    rd_reg      <= rd_next;
    nb_tgt_reg  <= nb_tgt_next;
    nb_ovp_reg  <= nb_ovp_next;
    nb_pgl_reg  <= nb_pgl_next;
    nb_pglr_reg <= nb_pglr_next;
    co_tgt_reg  <= co_tgt_next;
    co_ovp_reg  <= co_ovp_next;
    co_pgl_reg  <= co_pgl_next;
    co_pglr_reg <= co_pglr_next;
    co_pgh_reg  <= co_pgh_next;
    co_pghr_reg <= co_pghr_next;
    ph_reg      <= ph_next;
    add_reg     <= add_next;
    drop_reg    <= drop_next;
  end

  // Outputs straight from flops
  assign reg_rd_data         = rd_reg;
  assign nb_target_mv        = nb_tgt_reg;
  assign nb_ovp_mv           = nb_ovp_reg;
  assign nb_pg_low_mv        = nb_pgl_reg;
  assign nb_pg_low_rel_mv    = nb_pglr_reg;
  assign core_target_mv      = co_tgt_reg;
  assign core_ovp_mv         = co_ovp_reg;
  assign core_pg_low_mv      = co_pgl_reg;
  assign core_pg_low_rel_mv  = co_pglr_reg;
  assign core_pg_high_mv     = co_pgh_reg;
  assign core_pg_high_rel_mv = co_pghr_reg;
  assign psave_phase_code    = ph_reg;
  assign psave_add_cycles    = add_reg;
  assign psave_drop_cycles   = drop_reg;
endmodule

// *** rmp_consts.svh ***
`ifndef RMP_CONSTS_SVH
`define RMP_CONSTS_SVH

// Register offsets on the serial register port
`define RMP_ADDR_NB        8'h00
`define RMP_ADDR_CORE      8'h01
`define RMP_ADDR_PSAVE     8'h02
`define RMP_NUM_REGS       2'h3

// Initial states
`define RMP_RST_NB         8'h00
`define RMP_RST_CORE       8'h00
`define RMP_RST_PSAVE      8'h01

// Margining register fields
`define RMP_OVP_BIT        7
`define RMP_PGOOD_BIT      6
`define RMP_OFS_MSB        5
`define RMP_OFS_SIGN       5

// Power-save register fields
`define RMP_PS_RSVD_BIT    7
`define RMP_PS_OFS_DIS_BIT 6
`define RMP_PS_DROP_MSB    5
`define RMP_PS_DROP_LSB    4
`define RMP_PS_ADD_MSB     3
`define RMP_PS_ADD_LSB     2
`define RMP_PS_PH_MSB      1
`define RMP_PS_PH_LSB      0

// Voltages in mV
`define RMP_OFS_STEP_MV    14'sh0019
`define RMP_OVP_FLOOR_MV   14'sh0708
`define RMP_OVP_LO_MV      14'sh00FA
`define RMP_OVP_HI_MV      14'sh01F4
`define RMP_PG_UP_LO_MV    14'sh00FA
`define RMP_PG_UP_HI_MV    14'sh012C
`define RMP_PG_DN_LO_MV    14'sh012C
`define RMP_PG_DN_HI_MV    14'sh015E
`define RMP_PG_HYST_MV     14'sh0032

// Phase spacing in PWM cycles
`define RMP_SPACE_1        3'h1
`define RMP_SPACE_2        3'h2
`define RMP_SPACE_4        3'h4
`define RMP_SPACE_ALL      3'h0

`endif

// *** rmp_pkg.sv ***
package rmp_pkg;
  typedef logic [7:0]         rmp_byte_t;
  typedef logic signed [13:0] rmp_mv_t;
  typedef logic [11:0]        rmp_vref_t;
  typedef enum logic [1:0] {
    RMP_REG_NB,
    RMP_REG_CORE,
    RMP_REG_PSAVE,
    RMP_REG_NONE
  } rmp_reg_sel_t;
endpackage

// *** rmp_regs_if.sv ***
`timescale 1ns/1ps
interface rmp_regs_if;
  import rmp_pkg::*;
  logic         wr_en;
  rmp_reg_sel_t wr_sel;
  rmp_byte_t    wr_data;
  logic         apply;
  rmp_reg_sel_t rd_sel;
  rmp_byte_t    rd_data;
  rmp_byte_t    live_nb;
  rmp_byte_t    live_core;
  rmp_byte_t    live_psave;
  modport store (input wr_en, wr_sel, wr_data, apply, rd_sel,
                 output rd_data, live_nb, live_core, live_psave);
  modport ctrl  (output wr_en, wr_sel, wr_data, apply, rd_sel,
                 input rd_data, live_nb, live_core, live_psave);
endinterface

// *** rmp_reg_store.sv ***
`timescale 1ns/1ps
`include "rmp_consts.svh"
module rmp_reg_store (
  // Clock and clear
  input wire logic  sys_clk,
  input wire logic  clr,
  // Register traffic
  rmp_regs_if.store rb
);
  import rmp_pkg::*;

  rmp_byte_t stage_reg [3];
  rmp_byte_t stage_next [3];
  rmp_byte_t live_reg [3];
  rmp_byte_t live_next [3];
  rmp_byte_t rdat_reg;
  rmp_byte_t rdat_next;

  // Staged bytes take writes; live copy follows at end of transaction
  always_comb begin
    stage_next = stage_reg;
    live_next  = live_reg;
    rdat_next  = 8'h00;
    if (clr) begin
      stage_next[RMP_REG_NB]    = `RMP_RST_NB;
      stage_next[RMP_REG_CORE]  = `RMP_RST_CORE;
      stage_next[RMP_REG_PSAVE] = `RMP_RST_PSAVE;
      live_next     = stage_next;
    end else begin
      if (rb.wr_en && rb.wr_sel != RMP_REG_NONE) begin
        stage_next[rb.wr_sel] = rb.wr_data;
      end
      // Live update never stalls regulation, so default rewrites act at once
      if (rb.apply) begin
        live_next = stage_next;
      end
      // Unmapped reads return zero
      if (rb.rd_sel != RMP_REG_NONE) begin
        rdat_next = stage_next[rb.rd_sel];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    stage_reg <= stage_next;
    live_reg  <= live_next;
    rdat_reg  <= rdat_next;
  end

  assign rb.rd_data    = rdat_reg;
  assign rb.live_nb    = live_reg[RMP_REG_NB];
  assign rb.live_core  = live_reg[RMP_REG_CORE];
  assign rb.live_psave = live_reg[RMP_REG_PSAVE];
endmodule

// *** rmp_margin_regs_sva.sv ***
`timescale 1ns/1ps
module rmp_margin_sva (
  // Clock, reset and supply
  input wire logic               sys_clk,
  input wire logic               rst,
  input wire logic               supply_low,
  // Register port and reference
  input wire logic               reg_wr_en,
  input wire logic [7:0]         reg_wr_addr,
  input wire logic [7:0]         reg_wr_data,
  input wire logic               reg_txn_done,
  input wire rmp_pkg::rmp_vref_t nb_vref_mv,
  // Operating parameters
  input wire rmp_pkg::rmp_mv_t   nb_target_mv,
  input wire rmp_pkg::rmp_mv_t   nb_ovp_mv,
  input wire rmp_pkg::rmp_mv_t   nb_pg_low_mv,
  input wire rmp_pkg::rmp_mv_t   nb_pg_low_rel_mv,
  input wire rmp_pkg::rmp_mv_t   core_target_mv,
  input wire rmp_pkg::rmp_mv_t   core_pg_low_mv,
  input wire rmp_pkg::rmp_mv_t   core_pg_high_mv,
  input wire rmp_pkg::rmp_mv_t   core_pg_high_rel_mv,
  input wire logic [1:0]         psave_phase_code,
  input wire logic [2:0]         psave_add_cycles,
  input wire logic [2:0]         psave_drop_cycles
);
  import rmp_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Transaction-ending bytes, which apply at once
  logic nb_apply;
  logic ps_apply;
  assign nb_apply = reg_wr_en && reg_txn_done && reg_wr_addr == 8'h00 && !supply_low;
  assign ps_apply = reg_wr_en && reg_txn_done && reg_wr_addr == 8'h02 && !supply_low;
  function automatic logic [2:0] spc(input logic [1:0] c);
    return c == 2'h3 ? 3'h0 : 3'h1 << c;
  endfunction
  AST_RST_STATE:
    assert property ($fell(rst) |-> psave_phase_code == 2'h1 && psave_add_cycles == 3'h1 && psave_drop_cycles == 3'h1)
      else $error("power-save outputs not at reset state");
  AST_SUPPLY_CLEAR:
    assert property (supply_low [*6] |-> psave_phase_code == 2'h1 && psave_add_cycles == 3'h1)
      else $error("supply dropout did not clear registers");
  AST_PHASE_CODE:
    assert property (ps_apply |-> ##2 psave_phase_code == $past(reg_wr_data[1:0], 2))
      else $error("phase code not taken from written byte");
  AST_SPACING:
    assert property (ps_apply |-> ##2 psave_add_cycles == spc($past(reg_wr_data[3:2], 2))
      && psave_drop_cycles == spc($past(reg_wr_data[5:4], 2))) else $error("phase spacing wrong");
  AST_OFFSET:
    assert property (nb_apply ##1 $stable(nb_vref_mv) |-> ##1 nb_target_mv == $signed({2'h0, $past(nb_vref_mv)})
      + $signed($past(reg_wr_data[5:0], 2)) * 14'sh0019) else $error("offset not added to reference");
  AST_OVP_LEVEL:
    assert property (nb_ovp_mv >= 14'sh0708 && nb_ovp_mv >= nb_target_mv + 14'sh00FA
      && (nb_ovp_mv == 14'sh0708 || nb_ovp_mv - nb_target_mv inside {14'sh00FA, 14'sh01F4}))
      else $error("overvoltage level wrong");
  AST_PG_HYST:
    assert property (nb_pg_low_rel_mv - nb_pg_low_mv == 14'sh0032 && core_pg_high_mv - core_pg_high_rel_mv == 14'sh0032)
      else $error("power-good hysteresis wrong");
  AST_PG_WINDOW:
    assert property (core_target_mv - core_pg_low_mv == core_pg_high_mv - core_target_mv + 14'sh0032
      && nb_target_mv - nb_pg_low_mv inside {14'sh012C, 14'sh015E}) else $error("power-good window wrong");
  // Main scenarios reached
  cover property (ps_apply);
  cover property (supply_low [*6]);
  cover property (core_target_mv - core_pg_low_mv == 14'sh015E);
endmodule
bind rmp_margin_regs rmp_margin_sva rmp_margin_sva_inst (.sys_clk, .rst, .supply_low, .reg_wr_en, .reg_wr_addr,
  .reg_wr_data, .reg_txn_done, .nb_vref_mv, .nb_target_mv, .nb_ovp_mv, .nb_pg_low_mv, .nb_pg_low_rel_mv,
  .core_target_mv, .core_pg_low_mv, .core_pg_high_mv, .core_pg_high_rel_mv, .psave_phase_code,
  .psave_add_cycles, .psave_drop_cycles);

// *** rmp_host_model.sv ***
`timescale 1ns/1ps
module rmp_host_model (
  // Clock
  input wire logic  sys_clk,
  // Register port toward the block
  output logic       reg_wr_en,
  output logic [7:0] reg_wr_addr,
  output logic [7:0] reg_wr_data,
  output logic       reg_txn_done,
  output logic [7:0] reg_rd_addr
);
  // Quiet port at time zero
  initial begin
    reg_wr_en = 1'b0;
    reg_txn_done = 1'b0;
    reg_wr_addr = 8'h00;
    reg_wr_data = 8'h00;
    reg_rd_addr = 8'h00;
  end
  // One byte per cycle; stop flagged with the last byte
  task automatic put(input logic [7:0] a, input logic [7:0] d, input logic last);
    @(negedge sys_clk);
    reg_wr_en = 1'b1;
    reg_wr_addr = a;
    reg_wr_data = d;
    reg_txn_done = last;
  endtask
  // Released lines inverted so a stale byte never passes for data
  task automatic idle();
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
    reg_txn_done = 1'b0;
    reg_wr_addr = ~reg_wr_addr;
    reg_wr_data = ~reg_wr_data;
  endtask
  task automatic sel(input logic [7:0] a);
    @(negedge sys_clk);
    reg_rd_addr = a;
  endtask
endmodule

// *** rmp_tb.sv ***
`timescale 1ns/1ps
module tb;
  import rmp_pkg::*;
  // Clock, resets and environment
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       supply_low = 1'b0;
  logic       psave_active = 1'b0;
  rmp_vref_t  nb_vref_mv = 12'h4B0;
  rmp_vref_t  core_vref_mv = 12'h4B0;
  logic       reg_wr_en, reg_txn_done;
  logic [7:0] reg_wr_addr, reg_wr_data, reg_rd_addr, reg_rd_data;
  rmp_mv_t    nb_target_mv, nb_ovp_mv, nb_pg_low_mv, nb_pg_low_rel_mv, core_target_mv, core_ovp_mv;
  rmp_mv_t    core_pg_low_mv, core_pg_low_rel_mv, core_pg_high_mv, core_pg_high_rel_mv;
  logic [1:0] psave_phase_code;
  logic [2:0] psave_add_cycles, psave_drop_cycles;
  // Model registers and counters
  int         stg [3];
  int         live [3];
  int         mismatches = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  always #2 sys_clk = ~sys_clk;
  rmp_margin_regs rmp_margin_regs_inst (.sys_clk, .rst, .supply_low, .reg_wr_en, .reg_wr_addr, .reg_wr_data,
    .reg_txn_done, .reg_rd_addr, .reg_rd_data, .nb_vref_mv, .core_vref_mv, .psave_active, .nb_target_mv,
    .nb_ovp_mv, .nb_pg_low_mv, .nb_pg_low_rel_mv, .core_target_mv, .core_ovp_mv, .core_pg_low_mv,
    .core_pg_low_rel_mv, .core_pg_high_mv, .core_pg_high_rel_mv, .psave_phase_code, .psave_add_cycles,
    .psave_drop_cycles);
  rmp_host_model rmp_host_model_inst (.sys_clk, .reg_wr_en, .reg_wr_addr, .reg_wr_data, .reg_txn_done,
    .reg_rd_addr);
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard, a few times the expected run
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  function automatic int ofs(input int b);
    return $signed(b[5:0]) * 25;
  endfunction
  function automatic int sp(input int c);
    return c == 3 ? 0 : 1 << c;
  endfunction
  function automatic int mx(input int a);
    return a > 1800 ? a : 1800;
  endfunction
  // Byte into the model; stop makes staged bytes live
  task automatic wr(input int a, input int d, input bit last);
    rmp_host_model_inst.put(8'(a), 8'(d), last);
    if (a < 3) stg[a] = d;
    if (last) live = stg;
  endtask
  // Let parameters settle, compare all of them, then read every place back
  task automatic settle();
    int t;
    int c;
    int b;
    rmp_host_model_inst.idle();
    repeat (2) @(negedge sys_clk);
    t = nb_vref_mv + ofs(live[0]);
    c = core_vref_mv + ((psave_active && live[2][6]) ? 0 : ofs(live[1]));
    b = live[1][6] ? 50 : 0;
    chk("nb_target", nb_target_mv, 16'(t));
    chk("nb_ovp", nb_ovp_mv, 16'(mx(t + (live[0][7] ? 500 : 250))));
    chk("nb_pg_low", nb_pg_low_mv, 16'(t - (live[0][6] ? 350 : 300)));
    chk("nb_pg_rel", nb_pg_low_rel_mv, 16'(t - (live[0][6] ? 300 : 250)));
    chk("core_target", core_target_mv, 16'(c));
    chk("core_ovp", core_ovp_mv, 16'(mx(c + (live[1][7] ? 500 : 250))));
    chk("core_pg_low", core_pg_low_mv, 16'(c - 300 - b));
    chk("core_pg_low_rel", core_pg_low_rel_mv, 16'(c - 250 - b));
    chk("core_pg_high", core_pg_high_mv, 16'(c + 250 + b));
    chk("core_pg_high_rel", core_pg_high_rel_mv, 16'(c + 200 + b));
    chk("phase_code", psave_phase_code, 16'(live[2] & 3));
    chk("add_cycles", psave_add_cycles, 16'(sp(live[2] >> 2 & 3)));
    chk("drop_cycles", psave_drop_cycles, 16'(sp(live[2] >> 4 & 3)));
    for (int a = 0; a < 4; a++) begin
      rmp_host_model_inst.sel(a < 3 ? 8'(a) : 8'(3 + $urandom % 253));
      repeat (2) @(negedge sys_clk);
      chk("rd_data", reg_rd_data, 16'(a < 3 ? stg[a] : 0));
    end
  endtask
  initial begin
    void'($urandom(78));
    stg = '{0, 0, 1};
    live = stg;
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    settle();
    // Every offset code, burst of two bytes, random trip bits and references
    for (int i = 0; i < 64; i++) begin
      nb_vref_mv = 12'($urandom);
      core_vref_mv = 12'($urandom);
      wr(1, int'($urandom % 4) * 64 + 63 - i, 0);
      wr(0, int'($urandom % 4) * 64 + i, 1);
      settle();
    end
    // Every power-save field code, with and without power-save mode
    for (int i = 0; i < 16; i++) begin
      psave_active = i[0];
      wr(1, int'($urandom % 256), 0);
      wr(2, int'($urandom % 2) * 128 + (i >> 1 & 1) * 64 + (i & 3) * 16 + (i >> 2) * 4 + ((i + (i >> 2)) & 3), 1);
      settle();
    end
    // Staged bytes wait for the stop; unmapped bytes vanish
    wr(0, 191, 0);
    wr(3, 85, 0);
    wr(255, 170, 0);
    settle();
    wr(2, 129, 1);
    settle();
    // Writing the initial states restores default behaviour
    wr(0, 0, 0);
    wr(1, 0, 0);
    wr(2, 1, 1);
    settle();
    // Supply dropout, then a second reset, each in mid-run
    for (int k = 0; k < 2; k++) begin
      // Non-default power-save byte, so a missed clear shows
      wr(2, 174, 0);
      wr(k, 165, 1);
      settle();
      if (k == 0) supply_low = 1'b1;
      else rst = 1'b1;
      repeat (8) @(negedge sys_clk);
      supply_low = 1'b0;
      rst = 1'b0;
      stg = '{0, 0, 1};
      live = stg;
      settle();
    end
    tally_and_finish();
  end
endmodule
